/* acpf_capture.sv */
// Capture model counting words latched on the forwarded clock
`timescale 1ns/1ps
`default_nettype none
module acpf_capture #(
  parameter int DATA_W = 14
) (
  input  wire logic              fwd_clock_pos,
  input  wire logic              out_enable,
  input  wire logic [DATA_W-1:0] sample_out,
  output var  int                cap_count
);
  int cnt = 0;
  always_comb cap_count = cnt;
  // A released bus latches nothing, so low power shows as a stalled count
  always @(posedge fwd_clock_pos) begin
    if (out_enable === 1'b1 && ^sample_out !== 1'bx) begin
      cnt <= cnt + 1;
    end
  end
endmodule // acpf_capture
`default_nettype wire

/* acpf_ctrl.sv */
// Clock divide, power state and output format control around the converter core
`timescale 1ns/1ps
`default_nettype none
`include "acpf_defs.svh"
module acpf_ctrl
  import acpf_pkg::*;
#(
  parameter int          DATA_W     = 14,
  parameter int unsigned RELOCK_CYC = `ACPF_RELOCK_CYC
) (
  input  wire  logic              sys_clk,
  input  wire  logic              rst_b,
  input  wire  acpf_tri_t         divide_select_pin,
  input  wire  acpf_tri_t         power_state_pin,
  input  wire  logic              divider_sync_reset_pos,
  input  wire  logic              divider_sync_reset_neg,
  input  wire  logic              recal_reset_n,
  input  wire  logic              cfg_wr,
  input  wire  logic [7:0]        cfg_addr,
  input  wire  logic [7:0]        cfg_wdata,
  output logic [7:0]              cfg_rdata,
  input  wire  logic [DATA_W-1:0] core_data,
  input  wire  logic              core_over_range,
  output logic [DATA_W-1:0]       sample_out,
  output logic                    over_range_out,
  output logic                    fwd_clock_pos,
  output logic                    fwd_clock_neg,
  output logic                    out_enable,
  output logic                    out_cmos,
  output logic                    out_ddr,
  output logic                    lvds_low_current,
  output logic                    dll_slow_range,
  output logic                    dll_locked,
  output logic [2:0]              power_state
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0] div_s1, div_s2, pwr_s1, pwr_s2;
  logic       rp_s1, rp_s2, rn_s1, rn_s2, rc_s1, rc_s2;

  // Reset values match the idle pin levels, so no false event follows reset
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_s1 <= 2'h1;
      div_s2 <= 2'h1;
      pwr_s1 <= 2'h0;
      pwr_s2 <= 2'h0;
    end else begin
      div_s1 <= divide_select_pin;
      div_s2 <= div_s1;
      pwr_s1 <= power_state_pin;
      pwr_s2 <= pwr_s1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rp_s1 <= 1'h0;
      rp_s2 <= 1'h0;
      rn_s1 <= 1'h1;
      rn_s2 <= 1'h1;
    end else begin
      rp_s1 <= divider_sync_reset_pos;
      rp_s2 <= rp_s1;
      rn_s1 <= divider_sync_reset_neg;
      rn_s2 <= rn_s1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rc_s1 <= 1'h1;
      rc_s2 <= 1'h1;
    end else begin
      rc_s1 <= recal_reset_n;
      rc_s2 <= rc_s1;
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  // Pin codes: 0 tied low, 1 floating, 2 tied high
  logic [7:0] out_mode;
  logic [2:0] div_ovr;
  logic [3:0] pwr_ovr;

  // Writes to unmapped addresses change nothing
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_mode <= `ACPF_OUT_MODE_RST;
    end else if (cfg_wr && cfg_addr == `ACPF_OUT_MODE_ADDR) begin
      out_mode <= cfg_wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_ovr <= 3'h0;
    end else if (cfg_wr && cfg_addr == `ACPF_DIVIDE_SELECT_PIN_ADDR) begin
      div_ovr <= cfg_wdata[2:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_ovr <= 4'h0;
    end else if (cfg_wr && cfg_addr == `ACPF_PWR_ADDR) begin
      pwr_ovr <= cfg_wdata[3:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_rdata <= 8'h00;
    end else begin
      unique case (cfg_addr)
        `ACPF_OUT_MODE_ADDR: cfg_rdata <= out_mode;
        `ACPF_DIVIDE_SELECT_PIN_ADDR:   cfg_rdata <= {5'h00, div_ovr};
        `ACPF_PWR_ADDR:      cfg_rdata <= {1'h0, power_state, pwr_ovr};
        default:             cfg_rdata <= 8'h00;
      endcase
    end
  end

  // ************************************************************
  // Divide ratio and power state selection
  // ************************************************************
  // Override bit 2 (divide) or bit 3 (power) set means the serial value wins over the pin
  logic [2:0] div_ratio, next_div_ratio;
  logic [2:0] next_power;

  always_comb begin
    if (div_ovr[2]) begin
      next_div_ratio = (div_ovr[1:0] == 2'h0) ? 3'h2 :
                       (div_ovr[1:0] == 2'h2) ? 3'h4 : 3'h1;
    end else begin
      next_div_ratio = (div_s2 == 2'h0) ? 3'h2 :
                       (div_s2 == 2'h2) ? 3'h4 : 3'h1;
    end
    if (pwr_ovr[3]) begin
      next_power = (pwr_ovr[1:0] == 2'h1) ? ACPF_PWR_NAP :
                   (pwr_ovr[1:0] == 2'h2) ? ACPF_PWR_SLEEP : ACPF_PWR_NORMAL;
    end else begin
      next_power = (pwr_s2 == 2'h0) ? ACPF_PWR_NORMAL :
                   (pwr_s2 == 2'h1) ? ACPF_PWR_SLEEP : ACPF_PWR_NAP;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_ratio <= 3'h1;
    end else begin
      div_ratio <= next_div_ratio;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_state <= ACPF_PWR_NORMAL;
    end else begin
      power_state <= next_power;
    end
  end

  // ************************************************************
  // Delay-locked loop relock tracking
  // ************************************************************
  // Relock counted at full rate; slower rates only make this optimistic
  logic [31:0] lock_cnt;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_cnt   <= 32'h0;
      dll_locked <= 1'h0;
    end else if (next_div_ratio != div_ratio) begin
      lock_cnt   <= 32'h0;
      dll_locked <= 1'h0;
    end else if (lock_cnt < RELOCK_CYC) begin
      lock_cnt   <= lock_cnt + 32'h1;
      dll_locked <= 1'h0;
    end else begin
      dll_locked <= 1'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dll_slow_range <= 1'h0;
    end else begin
      dll_slow_range <= out_mode[`ACPF_F_DLL_SLOW];
    end
  end

  // ************************************************************
  // Clock divider with synchronous reset
  // ************************************************************
  // Reset counted only when the pair is a valid complement
  logic       div_rst, sample_en, recal_hold;
  logic [1:0] div_cnt;
  logic       fclk;

  assign div_rst    = rp_s2 & ~rn_s2;
  assign recal_hold = ~rc_s2 & (div_ratio != 3'h1);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= 2'h0;
    end else if (div_rst || div_ratio == 3'h1) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= (div_cnt + 2'h1) & 2'((div_ratio == 3'h2) ? 2'h1 : 2'h3);
    end
  end

  assign sample_en = (div_cnt == 2'h0) && !(div_rst && div_ratio != 3'h1);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fclk <= 1'h0;
    end else if (recal_hold) begin
      fclk <= 1'h0;
    end else if (div_ratio == 3'h1) begin
      fclk <= ~fclk;
    end else begin
      fclk <= (div_cnt < 2'(div_ratio >> 1));
    end
  end

  // ************************************************************
  // Pipeline latency and code formatting
  // ************************************************************
  // Fixed latency holds across a divider reset
  logic [DATA_W-1:0] pipe    [`ACPF_LATENCY];
  logic              or_pipe [`ACPF_LATENCY];
  logic [DATA_W-1:0] ob, gray, next_code;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pipe[0]    <= '0;
      or_pipe[0] <= 1'h0;
    end else if (sample_en) begin
      pipe[0]    <= core_data;
      or_pipe[0] <= core_over_range;
    end
  end

  // Stages move only on a sample enable, so latency counts sample cycles
  for (genvar s = 1; s < `ACPF_LATENCY; s++) begin : g_stage
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        pipe[s]    <= '0;
        or_pipe[s] <= 1'h0;
      end else if (sample_en) begin
        pipe[s]    <= pipe[s-1];
        or_pipe[s] <= or_pipe[s-1];
      end
    end
  end

  assign ob = pipe[`ACPF_LATENCY-1];

  // Top bit passes through; each lower bit compares with its upper neighbour
  assign gray[DATA_W-1] = ob[DATA_W-1];
  for (genvar b = 0; b < DATA_W - 1; b++) begin : g_gray
    assign gray[b] = ob[b] ^ ob[b+1];
  end

  always_comb begin
    unique case (out_mode[`ACPF_F_FMT_HI:`ACPF_F_FMT_LO])
      ACPF_FMT_OFFSET: next_code = ob;
      ACPF_FMT_GRAY:   next_code = gray;
      default:         next_code = {~ob[DATA_W-1], ob[DATA_W-2:0]};
    endcase
  end

  // ************************************************************
  // Output drive
  // ************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_out     <= '0;
      over_range_out <= 1'h0;
    end else if (sample_en) begin
      sample_out     <= next_code;
      over_range_out <= or_pipe[`ACPF_LATENCY-1];
    end
  end

  // Both legs come from flops on one edge so the pair never skews apart
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fwd_clock_pos <= 1'h0;
      fwd_clock_neg <= 1'h1;
    end else begin
      fwd_clock_pos <= fclk;
      fwd_clock_neg <= ~fclk;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_enable <= 1'h0;
    end else begin
      out_enable <= (power_state == ACPF_PWR_NORMAL);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_cmos         <= 1'h0;
      out_ddr          <= 1'h0;
      lvds_low_current <= 1'h0;
    end else begin
      out_cmos         <= out_mode[`ACPF_F_CMOS];
      out_ddr          <= out_mode[`ACPF_F_DDR];
      lvds_low_current <= out_mode[`ACPF_F_LOWI];
    end
  end

endmodule // acpf_ctrl
`default_nettype wire

/* acpf_ctrl_props.sv */
// Port checks for acpf_ctrl
`timescale 1ns/1ps
`default_nettype none
module acpf_ctrl_props
  import acpf_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cfg_wr,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic fwd_clock_pos,
  input wire logic fwd_clock_neg,
  input wire logic out_enable,
  input wire logic out_cmos,
  input wire logic out_ddr,
  input wire logic lvds_low_current,
  input wire logic dll_slow_range,
  input wire logic dll_locked,
  input wire logic [2:0] power_state
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire logic w73 = cfg_wr && cfg_addr == 8'h73;
  wire logic w72 = cfg_wr && cfg_addr == 8'h72;
  clk_pair_a: assert property (fwd_clock_neg == !fwd_clock_pos)
    else $error("clock pair");
  // Two cycles allowed, out_enable may trail the state by one register
  out_tristate_a: assert property (
    (power_state != ACPF_PWR_NORMAL) [*2] |-> !out_enable) else $error("driven");
  out_form_a: assert property (
    w73 |-> ##2 {out_ddr, out_cmos} == $past(cfg_wdata[3:2], 2)) else $error("form");
  drive_cur_a: assert property (
    w73 |-> ##2 lvds_low_current == $past(cfg_wdata[4], 2)) else $error("current");
  dll_range_a: assert property (
    w73 |-> ##2 dll_slow_range == $past(cfg_wdata[5], 2)) else $error("range");
  fmt_read_a: assert property (
    w73 ##1 (!cfg_wr && cfg_addr == 8'h73) |=> cfg_rdata[5:0] == $past(cfg_wdata[5:0], 2))
    else $error("mode read");
  div_read_a: assert property (
    w72 ##1 (!cfg_wr && cfg_addr == 8'h72) |=> cfg_rdata[2:0] == $past(cfg_wdata[2:0], 2))
    else $error("divide read");
  relock_hold_a: assert property (
    $fell(dll_locked) |=> (!dll_locked) [*8]) else $error("relock");
  c_mode: cover property (w73);
  c_nap: cover property (power_state == ACPF_PWR_NAP);
  c_relock: cover property ($fell(dll_locked));
endmodule // acpf_ctrl_props
bind acpf_ctrl acpf_ctrl_props acpf_ctrl_props_inst (.sys_clk, .rst_b, .cfg_wr, .cfg_addr,
  .cfg_wdata, .cfg_rdata, .fwd_clock_pos, .fwd_clock_neg, .out_enable, .out_cmos, .out_ddr,
  .lvds_low_current, .dll_slow_range, .dll_locked, .power_state);
`default_nettype wire

/* acpf_defs.svh */
// Offsets, field positions, reset values and timing counts for the converter control block
`ifndef ACPF_DEFS_SVH
`define ACPF_DEFS_SVH
`define ACPF_OUT_MODE_ADDR     8'h73
`define ACPF_DIVIDE_SELECT_PIN_ADDR       8'h72
`define ACPF_PWR_ADDR          8'h25
`define ACPF_F_FMT_LO          0
`define ACPF_F_FMT_HI          1
`define ACPF_F_CMOS            2
`define ACPF_F_DDR             3
`define ACPF_F_LOWI            4
`define ACPF_F_DLL_SLOW        5
`define ACPF_OUT_MODE_RST      8'h01
`define ACPF_LATENCY           10
`define ACPF_RELOCK_NS         52000
`define ACPF_CLK_NS            5
`define ACPF_RELOCK_CYC        (`ACPF_RELOCK_NS / `ACPF_CLK_NS)
`endif

/* acpf_pkg.sv */
// Types shared by the converter control block
package acpf_pkg;
  typedef enum logic [1:0] {ACPF_FMT_OFFSET = 2'h0, ACPF_FMT_TWOS = 2'h1,
                            ACPF_FMT_GRAY = 2'h2} acpf_fmt_e;
  typedef enum logic [2:0] {ACPF_PWR_NORMAL = 3'h1, ACPF_PWR_NAP = 3'h2,
                            ACPF_PWR_SLEEP = 3'h4} acpf_pwr_e;
  typedef logic [1:0] acpf_tri_t;
endpackage

/* tb_acpf_ctrl.sv */
// Self-checking bench for acpf_ctrl
`timescale 1ns/1ps
`default_nettype none
module tb_acpf_ctrl;
  import acpf_pkg::*;
  localparam int DW = 14;
  logic sys_clk = 1'b0, rst_b = 1'b0, cfg_wr = 1'b0, core_over_range = 1'b0;
  logic divider_sync_reset_pos = 1'b0, divider_sync_reset_neg = 1'b1, recal_reset_n = 1'b1;
  acpf_tri_t divide_select_pin = 2'h1, power_state_pin = 2'h0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, cfg_rdata, d;
  logic [DW-1:0] core_data = 14'h0000, sample_out;
  logic over_range_out, fwd_clock_pos, fwd_clock_neg, out_enable, out_cmos, out_ddr;
  logic lvds_low_current, dll_slow_range, dll_locked, ph [2];
  logic [2:0] power_state;
  logic [DW-1:0] tv [4] = '{14'h0000, 14'h3FFF, 14'h2000, 14'h0001};
  // Rows: expected state, power pin, override byte
  logic [12:0] pt [5] = '{13'h1100, 13'h0A00, 13'h0809, 13'h100A, 13'h0400};
  int cap_count, errors = 0, checked = 0, cyc = 0, k;
  int unsigned seed = 24;
  always #2.5 sys_clk = ~sys_clk;
  // Short relock count keeps the run brief
  acpf_ctrl #(.DATA_W(DW), .RELOCK_CYC(20)) acpf_ctrl_inst (.sys_clk, .rst_b, .divide_select_pin,
    .power_state_pin, .divider_sync_reset_pos, .divider_sync_reset_neg, .recal_reset_n, .cfg_wr,
    .cfg_addr, .cfg_wdata, .cfg_rdata, .core_data, .core_over_range, .sample_out, .over_range_out,
    .fwd_clock_pos, .fwd_clock_neg, .out_enable, .out_cmos, .out_ddr, .lvds_low_current,
    .dll_slow_range, .dll_locked, .power_state);
  acpf_capture #(.DATA_W(DW)) acpf_capture_inst (.fwd_clock_pos, .out_enable, .sample_out,
    .cap_count);
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [DW-1:0] fmt(int f, logic [DW-1:0] ob);
    if (f == 1) return ob ^ 14'h2000;
    if (f == 2) return ob ^ (ob >> 1);
    return ob;
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(posedge sys_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= v;
    @(posedge sys_clk);
    cfg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge sys_clk);
    cfg_addr <= a;
    tick(2);
    d = cfg_rdata;
  endtask
  task automatic report_and_stop(int hang);
    errors += hang;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) report_and_stop(1);
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(8'h73);
    chk(d, 8'h01);
    rd(8'h10);
    chk(d, 8'h00);
    wr(8'h73, 8'h3C);
    rd(8'h73);
    chk(d, 8'h3C);
    for (int f = 0; f < 3; f++) begin
      wr(8'h73, 8'(f));
      rd(8'h73);
      chk(d, 8'(f));
      tv[3] = 14'(xs());
      for (int j = 0; j < 4; j++) begin
        @(posedge sys_clk);
        core_data <= tv[j];
        core_over_range <= tv[j][0];
        tick(10);
        if (j > 0) chk(sample_out, fmt(f, tv[j-1]));
        tick(1);
        chk(sample_out, fmt(f, tv[j]));
        chk(over_range_out, tv[j][0]);
      end
    end
    wr(8'h72, 8'h06);
    rd(8'h72);
    chk(d, 8'h06);
    chk(dll_locked, 1'b0);
    for (k = 0; k < 99 && dll_locked !== 1'b1; k++) tick(1);
    chk(k, 19);
    @(posedge sys_clk);
    divide_select_pin <= 2'h2;
    tick(4);
    wr(8'h72, 8'h00);
    tick(5);
    chk(dll_locked, 1'b1);
    for (int r = 0; r < 2; r++) begin
      tick(int'(xs() % 4) * 2 + 1);
      @(posedge sys_clk);
      divider_sync_reset_pos <= 1'b1;
      divider_sync_reset_neg <= 1'b0;
      repeat (3) @(posedge sys_clk);
      divider_sync_reset_pos <= 1'b0;
      divider_sync_reset_neg <= 1'b1;
      tick(9);
      ph[r] = fwd_clock_pos;
    end
    chk(ph[0], ph[1]);
    @(posedge sys_clk);
    recal_reset_n <= 1'b0;
    tick(4);
    repeat (5) begin
      tick(1);
      chk(fwd_clock_pos, 1'b0);
    end
    @(posedge sys_clk);
    recal_reset_n <= 1'b1;
    k = cap_count;
    tick(8);
    chk(cap_count != k, 1'b1);
    @(posedge sys_clk);
    divide_select_pin <= 2'h0;
    tick(6);
    chk(dll_locked, 1'b0);
    for (int p = 0; p < 5; p++) begin
      @(posedge sys_clk);
      power_state_pin <= pt[p][9:8];
      wr(8'h25, pt[p][7:0]);
      tick(6);
      k = cap_count;
      chk(power_state, pt[p][12:10]);
      chk(out_enable, pt[p][10]);
      tick(12);
      chk(cap_count != k, pt[p][10]);
    end
    report_and_stop(0);
  end
endmodule // tb_acpf_ctrl
`default_nettype wire
